//--- rtl/ctg_consts.svh
`ifndef CTG_CONSTS_SVH
`define CTG_CONSTS_SVH

`define CTG_OFS_CONTROL      8'h18
`define CTG_OFS_START_DELAY  8'h19
`define CTG_OFS_LENGTH       8'h1A
`define CTG_OFS_STATUS       8'h30

`define CTG_CTRL_SRC_BIT     4
`define CTG_CTRL_POL_LO      6
`define CTG_CTRL_POL_HI      7

`define CTG_RST_CONTROL      8'h00
`define CTG_RST_START_DELAY  8'h04
`define CTG_RST_LENGTH       8'h28

`define CTG_STAT_CLAMP_BIT   0
`define CTG_STAT_BUSY_BIT    1
`define CTG_STAT_SRC_BIT     2

`define CTG_OFFSET_CYCLES    5'h10
// Arbitrary bus address
`define CTG_DEV_ADDR         7'h4C

`endif

//--- rtl/ctg_pkg.sv
package ctg_pkg;

	typedef struct packed {
		logic [7:0] red;
		logic [7:0] green;
		logic [7:0] blue;
	} ctg_pix_s;

	typedef enum logic [1:0] {
		CTG_CL_IDLE = 2'b00,
		CTG_CL_WAIT = 2'b01,
		CTG_CL_ON   = 2'b10
	} ctg_clamp_e;

	typedef enum logic [2:0] {
		CTG_SER_IDLE = 3'b000,
		CTG_SER_DEV  = 3'b001,
		CTG_SER_PTR  = 3'b010,
		CTG_SER_WR   = 3'b011,
		CTG_SER_RD   = 3'b100
	} ctg_ser_e;

endpackage

//--- rtl/ctg_sync.sv
`timescale 1ns/1ps
module ctg_sync #(
	parameter logic RESET_VAL = 1'b0
) (
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic d,
	output logic      q
);
	logic meta;

	// First stage feeds the second only
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta <= RESET_VAL;
			q    <= RESET_VAL;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule

//--- rtl/ctg_top.sv
`timescale 1ns/1ps
`include "ctg_consts.svh"

module ctg_top
	import ctg_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = `CTG_DEV_ADDR
) (
	input  wire logic     clk,
	input  wire logic     rst_b,
	input  wire logic     hsync,
	input  wire logic     clamp_pin,
	input  wire logic     scl,
	input  wire logic     sda_in,
	output logic          sda_out,
	output logic          sda_oe,
	input  wire ctg_pix_s adc_data,
	output ctg_pix_s      pix_out,
	output logic          clamp,
	output logic          offset_busy
);
	logic       hsync_s;
	logic       hsync_d;
	logic       clamp_pin_s;
	logic       scl_s;
	logic       scl_d;
	logic       sda_s;
	logic       sda_d;
	logic [7:0] clamp_control;
	logic [7:0] clamp_start_delay;
	logic [7:0] clamp_length;
	ctg_clamp_e cl_state;
	logic [7:0] cl_cnt;
	logic       clamp_d;
	logic [4:0] busy_cnt;
	ctg_pix_s   offset;
	ctg_ser_e   ser_state;
	logic       ack_ph;
	logic       ack_drive;
	logic       nacked;
	logic       rw_bit;
	logic [3:0] bit_cnt;
	logic [7:0] shift_in;
	logic [7:0] tx;
	logic [7:0] ptr;
	logic [7:0] rd_data;
	logic [7:0] status;
	logic       hs_trail;
	logic       ext_clamp;
	logic       src_ext;
	logic       start_c;
	logic       stop_c;
	logic       scl_rise;
	logic       scl_fall;
	logic [7:0] byte_in;

	ctg_sync u_sync_hs (.clk(clk), .rst_b(rst_b), .d(hsync), .q(hsync_s));
	ctg_sync u_sync_cl (.clk(clk), .rst_b(rst_b), .d(clamp_pin), .q(clamp_pin_s));
	ctg_sync #(.RESET_VAL(1'b1)) u_sync_scl (.clk(clk), .rst_b(rst_b), .d(scl), .q(scl_s));
	ctg_sync #(.RESET_VAL(1'b1)) u_sync_sda (.clk(clk), .rst_b(rst_b), .d(sda_in), .q(sda_s));

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hsync_d <= 1'b0;
			scl_d   <= 1'b1;
			sda_d   <= 1'b1;
		end else begin
			hsync_d <= hsync_s;
			scl_d   <= scl_s;
			sda_d   <= sda_s;
		end
	end

	assign hs_trail = hsync_d & ~hsync_s;
	assign src_ext  = clamp_control[`CTG_CTRL_SRC_BIT];
	// Bit 6 set means the pin is active low; bit 7 is stored only
	assign ext_clamp = clamp_pin_s ^ clamp_control[`CTG_CTRL_POL_LO];

	// Internal clamp timing, 8-bit counters over the full range
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cl_state <= CTG_CL_IDLE;
			cl_cnt   <= 8'h00;
		end else if (hsync_s) begin
			cl_state <= CTG_CL_IDLE;
			cl_cnt   <= 8'h00;
		end else begin
			case (cl_state)
				CTG_CL_IDLE: begin
					if (hs_trail && clamp_start_delay != 8'h00) begin
						cl_state <= CTG_CL_WAIT;
						cl_cnt   <= clamp_start_delay;
					end else if (hs_trail && clamp_length != 8'h00) begin
						cl_state <= CTG_CL_ON;
						cl_cnt   <= clamp_length;
					end
				end
				CTG_CL_WAIT: begin
					if (cl_cnt == 8'h01) begin
						cl_state <= (clamp_length != 8'h00) ? CTG_CL_ON : CTG_CL_IDLE;
						cl_cnt   <= clamp_length;
					end else begin
						cl_cnt <= cl_cnt - 8'h01;
					end
				end
				CTG_CL_ON: begin
					if (cl_cnt == 8'h01) begin
						cl_state <= CTG_CL_IDLE;
					end
					cl_cnt <= cl_cnt - 8'h01;
				end
				default: begin
					cl_state <= CTG_CL_IDLE;
					cl_cnt   <= 8'h00;
				end
			endcase
		end
	end

	// Both sources gated by hsync, so neither a late pin pulse nor a long count clamps on the sync tip
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			clamp   <= 1'b0;
			clamp_d <= 1'b0;
		end else begin
			clamp   <= src_ext ? (ext_clamp & ~hsync_s) : ((cl_state == CTG_CL_ON) & ~hsync_s);
			clamp_d <= clamp;
		end
	end

	// Offset trim window after the clamp ends
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			busy_cnt <= 5'h00;
		end else if (clamp) begin
			busy_cnt <= 5'h00;
		end else if (clamp_d) begin
			busy_cnt <= `CTG_OFFSET_CYCLES;
		end else if (busy_cnt != 5'h00) begin
			busy_cnt <= busy_cnt - 5'h01;
		end
	end
	assign offset_busy = (busy_cnt != 5'h00);

	// Last code seen during the clamp becomes the black offset
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			offset <= '0;
		end else if (clamp) begin
			offset <= adc_data;
		end
	end

	function automatic logic [7:0] ctg_sub(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] d;
		d = {1'b0, a} - {1'b0, b};
		ctg_sub = d[8] ? 8'h00 : d[7:0];
	endfunction

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pix_out <= '0;
		end else begin
			pix_out.red   <= ctg_sub(adc_data.red, offset.red);
			pix_out.green <= ctg_sub(adc_data.green, offset.green);
			pix_out.blue  <= ctg_sub(adc_data.blue, offset.blue);
		end
	end

	// Two-wire serial port
	assign start_c  = scl_s & sda_d & ~sda_s;
	assign stop_c   = scl_s & ~sda_d & sda_s;
	assign scl_rise = scl_s & ~scl_d;
	assign scl_fall = ~scl_s & scl_d;
	assign byte_in  = shift_in;

	assign status = {5'h00, src_ext, offset_busy, clamp};

	always_comb begin
		case (ptr)
			`CTG_OFS_CONTROL:     rd_data = clamp_control;
			`CTG_OFS_START_DELAY: rd_data = clamp_start_delay;
			`CTG_OFS_LENGTH:      rd_data = clamp_length;
			`CTG_OFS_STATUS:      rd_data = status;
			default:              rd_data = 8'h00;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ser_state <= CTG_SER_IDLE;
			ack_ph    <= 1'b0;
			ack_drive <= 1'b0;
			nacked    <= 1'b0;
			rw_bit    <= 1'b0;
			bit_cnt   <= 4'h0;
			shift_in  <= 8'h00;
			tx        <= 8'hFF;
			ptr       <= 8'h00;
		end else if (start_c) begin
			ser_state <= CTG_SER_DEV;
			ack_ph    <= 1'b0;
			ack_drive <= 1'b0;
			bit_cnt   <= 4'h0;
			tx        <= 8'hFF;
		end else if (stop_c) begin
			ser_state <= CTG_SER_IDLE;
			ack_ph    <= 1'b0;
			ack_drive <= 1'b0;
			tx        <= 8'hFF;
		end else if (scl_rise) begin
			if (ack_ph) begin
				nacked <= sda_s;
			end else if (ser_state != CTG_SER_IDLE) begin
				shift_in <= {shift_in[6:0], sda_s};
				bit_cnt  <= bit_cnt + 4'h1;
			end
		end else if (scl_fall && ser_state != CTG_SER_IDLE) begin
			if (!ack_ph && bit_cnt == 4'h8) begin
				ack_ph  <= 1'b1;
				bit_cnt <= 4'h0;
				tx      <= 8'hFF;
				case (ser_state)
					CTG_SER_DEV: begin
						ack_drive <= (byte_in[7:1] == DEV_ADDR);
						rw_bit    <= byte_in[0];
					end
					CTG_SER_PTR: begin
						ack_drive <= 1'b1;
						ptr       <= byte_in;
					end
					CTG_SER_WR: begin
						ack_drive <= 1'b1;
						ptr       <= ptr + 8'h01;
					end
					default: ack_drive <= 1'b0;
				endcase
			end else if (ack_ph) begin
				ack_ph    <= 1'b0;
				ack_drive <= 1'b0;
				case (ser_state)
					CTG_SER_DEV: begin
						if (!ack_drive) begin
							ser_state <= CTG_SER_IDLE;
						end else if (rw_bit) begin
							ser_state <= CTG_SER_RD;
							tx        <= rd_data;
							ptr       <= ptr + 8'h01;
						end else begin
							ser_state <= CTG_SER_PTR;
						end
					end
					CTG_SER_PTR: ser_state <= CTG_SER_WR;
					CTG_SER_WR:  ser_state <= CTG_SER_WR;
					CTG_SER_RD: begin
						if (nacked) begin
							ser_state <= CTG_SER_IDLE;
						end else begin
							tx  <= rd_data;
							ptr <= ptr + 8'h01;
						end
					end
					default: ser_state <= CTG_SER_IDLE;
				endcase
			end else if (ser_state == CTG_SER_RD && bit_cnt != 4'h0) begin
				tx <= {tx[6:0], 1'b1};
			end
		end
	end

	// Register writes land on the eighth falling edge of a data byte
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			clamp_control     <= `CTG_RST_CONTROL;
			clamp_start_delay <= `CTG_RST_START_DELAY;
			clamp_length      <= `CTG_RST_LENGTH;
		end else if (scl_fall && !start_c && !stop_c && !ack_ph && bit_cnt == 4'h8
			&& ser_state == CTG_SER_WR) begin
			case (ptr)
				`CTG_OFS_CONTROL:     clamp_control     <= byte_in;
				`CTG_OFS_START_DELAY: clamp_start_delay <= byte_in;
				`CTG_OFS_LENGTH:      clamp_length      <= byte_in;
				default:              clamp_control     <= clamp_control;
			endcase
		end
	end

	// Open drain: only ever pulls low
	assign sda_out = 1'b0;
	assign sda_oe  = (ack_ph && ack_drive) || (ser_state == CTG_SER_RD && !ack_ph && !tx[7]);
endmodule

//--- test/ctg_chk_sva.sv
`timescale 1ns/1ps
module ctg_chk
	import ctg_pkg::*;
(
	input logic     clk,
	input logic     rst_b,
	input logic     hsync,
	input logic     clamp,
	input logic     offset_busy,
	input logic     sda_out,
	input logic     sda_oe,
	input ctg_pix_s adc_data,
	input ctg_pix_s pix_out
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	chk_sync_overlap: assert property (hsync [*4] |-> !clamp)
		else $error("clamp during hsync");
	chk_porch_start: assert property ($rose(clamp) |-> !$past(hsync, 2))
		else $error("clamp rose next to hsync");
	chk_busy_len: assert property ($rose(offset_busy) |-> offset_busy [*8] ##1 offset_busy [*8] ##1 !offset_busy)
		else $error("offset busy not 16 cycles");
	chk_busy_follows: assert property ($fell(clamp) |-> ##[0:1] offset_busy)
		else $error("no offset run after clamp");
	chk_busy_cause: assert property ($rose(offset_busy) |-> $past(clamp) || $past(clamp, 2))
		else $error("offset run without clamp");
	chk_black_zero: assert property ((clamp && $stable(adc_data)) [*3] |-> pix_out == '0)
		else $error("black not zero while clamped");
	chk_pix_floor: assert property (pix_out.red <= $past(adc_data.red) &&
		pix_out.green <= $past(adc_data.green) && pix_out.blue <= $past(adc_data.blue))
		else $error("output above input code");
	chk_sda_open: assert property (!sda_out)
		else $error("data pin driven high");
	cover property ($rose(clamp));
	cover property ($rose(offset_busy));
	cover property ($rose(sda_oe));
endmodule

bind ctg_top ctg_chk chk (.clk(clk), .rst_b(rst_b), .hsync(hsync), .clamp(clamp), .offset_busy(offset_busy),
	.sda_out(sda_out), .sda_oe(sda_oe), .adc_data(adc_data), .pix_out(pix_out));

//--- test/ctg_src_model.sv
`timescale 1ns/1ps
module ctg_src_model
	import ctg_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic pol,
	output logic      hsync,
	output logic      clamp_pin,
	output ctg_pix_s  adc_data
);
	logic [9:0] cnt;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= 10'h000;
			hsync <= 1'b0;
			clamp_pin <= 1'b0;
			adc_data <= '0;
		end else begin
			cnt <= (cnt == 10'h2BB) ? 10'h000 : cnt + 10'h001;
			hsync <= cnt < 10'h00A;
			clamp_pin <= pol ^ (cnt >= 10'h014 && cnt < 10'h028);
			// Sync below black, so a mistimed clamp shows; long porch leaves room for the offset run
			adc_data <= (cnt < 10'h00A) ? 24'h05_0505 : (cnt < 10'h258) ? 24'h20_2122 : 24'h50_5152;
		end
	end
endmodule

//--- test/ctg_top_tb_top.sv
`timescale 1ns/1ps
`include "ctg_consts.svh"
module ctg_top_tb_top
	import ctg_pkg::*;
;
	logic     clk = 0, rst_b = 0, scl = 1, m_sda = 1, pol = 0;
	logic     hsync, clamp_pin, clamp, offset_busy, sda_out, sda_oe, sda_w;
	ctg_pix_s adc_data, pix_out;
	int       failures = 0, checks_done = 0, d0 = 0;
	always #50 clk = ~clk;
	// Open drain with pull-up
	assign sda_w = m_sda & ~(sda_oe & ~sda_out);
	ctg_src_model src (.clk(clk), .rst_b(rst_b), .pol(pol), .hsync(hsync), .clamp_pin(clamp_pin), .adc_data(adc_data));
	ctg_top dut (.clk(clk), .rst_b(rst_b), .hsync(hsync), .clamp_pin(clamp_pin), .scl(scl), .sda_in(sda_w),
		.sda_out(sda_out), .sda_oe(sda_oe), .adc_data(adc_data), .pix_out(pix_out), .clamp(clamp),
		.offset_busy(offset_busy));
	task check(input logic [31:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: %h vs %h", $time, seen, exp);
		end
	endtask
	task report_and_stop;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// Data moves 3 clk after scl, so no false start or stop
	task ph(input logic c, d);
		@(posedge clk) scl <= c;
		repeat (3) @(posedge clk);
		m_sda <= d;
		repeat (3) @(posedge clk);
	endtask
	task st;
		ph(1'b0, 1'b1);
		ph(1'b1, 1'b1);
		ph(1'b1, 1'b0);
	endtask
	task sp;
		ph(1'b0, 1'b0);
		ph(1'b1, 1'b0);
		ph(1'b1, 1'b1);
	endtask
	task xb(input logic [7:0] b, input logic a, output logic [7:0] r, output logic k);
		for (int i = 7; i >= 0; i--) begin
			ph(1'b0, b[i]);
			ph(1'b1, b[i]);
			r[i] = sda_w;
		end
		ph(1'b0, a);
		ph(1'b1, a);
		k = sda_w;
	endtask
	task wr(input logic [7:0] a, input logic [23:0] v);
		logic [7:0] r;
		logic       k;
		st;
		xb({`CTG_DEV_ADDR, 1'b0}, 1'b1, r, k);
		check(k, 1'b0);
		xb(a, 1'b1, r, k);
		for (int i = 2; i >= 0; i--) xb(v[i*8 +: 8], 1'b1, r, k);
		sp;
	endtask
	task rd(input logic [7:0] a, output logic [23:0] v);
		logic [7:0] r;
		logic       k;
		st;
		xb({`CTG_DEV_ADDR, 1'b0}, 1'b1, r, k);
		xb(a, 1'b1, r, k);
		st;
		xb({`CTG_DEV_ADDR, 1'b1}, 1'b1, r, k);
		check(k, 1'b0);
		for (int i = 2; i >= 0; i--) xb(8'hFF, i == 0, v[i*8 +: 8], k);
		sp;
	endtask
	task t_regs;
		logic [23:0] v;
		logic [7:0]  r;
		logic        k;
		rd(`CTG_OFS_CONTROL, v);
		check(v, {`CTG_RST_CONTROL, `CTG_RST_START_DELAY, `CTG_RST_LENGTH});
		rd(8'h20, v);
		check(v, 24'h00_0000);
		st;
		xb(8'h90, 1'b1, r, k);
		check(k, 1'b1);
		sp;
		$display("t_regs done");
	endtask
	task hs_wait;
		logic h;
		int   i;
		h = 1'b0;
		for (i = 0; i < 2000 && !(h && !hsync); i++) begin
			h = hsync;
			@(posedge clk);
		end
		if (i == 2000) begin
			failures++;
			report_and_stop;
		end
	endtask
	task run(input logic [7:0] c, dl, ln, input logic p, input int ew, ed);
		logic [23:0] v;
		int          i, s, w;
		// Writes then land mid-line, clear of sync; only the control write can fall in a clamp window, and it leaves the source unchanged, so no pulse is cut short
		hs_wait;
		wr(`CTG_OFS_CONTROL, {c, dl, ln});
		rd(`CTG_OFS_CONTROL, v);
		check(v, {c, dl, ln});
		pol <= p;
		hs_wait;
		s = -1;
		w = 0;
		for (i = 0; i < 640; i++) begin
			@(posedge clk);
			if (clamp === 1'b1) begin
				if (s < 0) s = i;
				w++;
			end
		end
		if (ed == -2) d0 = s;
		check(w, ew);
		if (ed >= 0) check(s - d0, ed);
		check(pix_out, 24'h30_3030);
	endtask
	task t_internal;
		run(8'h00, 8'h00, 8'h01, 1'b0, 1, -2);
		run(8'h00, 8'hFF, 8'hFF, 1'b0, 255, 255);
		run(8'h00, 8'h04, 8'h28, 1'b0, 40, 4);
		run(8'h00, 8'h04, 8'h00, 1'b0, 0, -1);
		$display("t_internal done");
	endtask
	task t_external;
		// Pin polarity flips only while the pin is ignored, so no inverted pulse train reaches the clamp
		run(8'h10, 8'h04, 8'h28, 1'b0, 20, -1);
		run(8'h00, 8'h04, 8'h28, 1'b1, 40, 4);
		run(8'h50, 8'h04, 8'h28, 1'b1, 20, -1);
		$display("t_external done");
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		t_regs;
		t_internal;
		t_external;
		report_and_stop;
	end
endmodule
